// File: tpts_pkg.sv
// tpts_pkg: constants for the transmit pulse template sequencer
// assumes an 8-bit microprocessor register port with 8-bit addresses
package tpts_pkg;
  localparam int unsigned TPTS_CODE_W   = 4;
  localparam int unsigned TPTS_NCODES   = 8;
  localparam int unsigned TPTS_IDX_W    = 3;
  localparam int unsigned TPTS_NPRESET  = 8;
  localparam int unsigned TPTS_BODY_N   = 4;
  // register offsets
  localparam logic [7:0] TPTS_RX_CFG_A  = 8'h03;
  localparam logic [7:0] TPTS_TX_CFG_A  = 8'h04;
  localparam logic [7:0] TPTS_DIAG_A    = 8'h0a;
  localparam logic [7:0] TPTS_LLEN_A    = 8'h14;
  localparam logic [7:0] TPTS_CIDX_A    = 8'h16;
  localparam logic [7:0] TPTS_CDATA_A   = 8'h17;
  // field positions
  localparam int unsigned TPTS_RX_UNI_B  = 0;
  localparam int unsigned TPTS_TX_UNI_B  = 0;
  localparam int unsigned TPTS_MLB_B     = 3;
  localparam int unsigned TPTS_TSEL_B    = 6;
  localparam int unsigned TPTS_CUST_EN_B = 7;
  localparam int unsigned TPTS_LLF_LO    = 0;
  // reset values
  localparam logic [7:0] TPTS_REG_RST   = 8'h00;
  localparam logic [7:0] TPTS_LLEN_RST  = 8'h40;
  localparam logic [3:0] TPTS_CODE_ZERO = 4'h0;
  localparam logic [2:0] TPTS_IDX_ZERO  = 3'h0;
  localparam logic [2:0] TPTS_IDX_LAST  = 3'h7;
  // preset templates, entry {len,idx}; len 7 repeats the longest range
  localparam logic [3:0] TPTS_PRESET [TPTS_NPRESET][TPTS_NCODES] = '{
    '{4'hb, 4'ha, 4'ha, 4'ha, 4'h3, 4'h3, 4'h2, 4'h1},
    '{4'hc, 4'hb, 4'ha, 4'ha, 4'h4, 4'h3, 4'h2, 4'h1},
    '{4'he, 4'hc, 4'hb, 4'hb, 4'h5, 4'h4, 4'h2, 4'h1},
    '{4'he, 4'hd, 4'hb, 4'hb, 4'h6, 4'h5, 4'h3, 4'h1},
    '{4'hf, 4'he, 4'hb, 4'hb, 4'h8, 4'h5, 4'h3, 4'h1},
    '{4'hf, 4'hc, 4'hb, 4'ha, 4'h8, 4'h5, 4'h3, 4'h1},
    '{4'hf, 4'hc, 4'ha, 4'ha, 4'ha, 4'h5, 4'h3, 4'h1},
    '{4'hf, 4'hc, 4'ha, 4'ha, 4'ha, 4'h5, 4'h3, 4'h1}
  };
  typedef enum logic [1:0] {
    TPTS_IDLE = 2'b00,
    TPTS_BODY = 2'b01,
    TPTS_TAIL = 2'b11
  } tpts_state_t;
endpackage

// File: tpts_code_store.sv
// tpts_code_store: eight custom amplitude codes in flip-flops
// assumes writes and reads come from the register port on ref_clk
`timescale 1ns/100ps
module tpts_code_store
  import tpts_pkg::*;
#(
  parameter int unsigned CODE_W = TPTS_CODE_W,
  parameter int unsigned NCODES = TPTS_NCODES,
  parameter int unsigned IDX_W  = TPTS_IDX_W
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // write port
  input  wire logic              wr_en,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [CODE_W-1:0] wr_code,
  // read ports
  input  wire logic [IDX_W-1:0]  host_idx,
  output logic      [CODE_W-1:0] host_code,
  input  wire logic [IDX_W-1:0]  seq_idx,
  output logic      [CODE_W-1:0] seq_code
);
  initial begin
    if (NCODES != (1 << IDX_W)) $error("code count must fill the index");
  end

  logic [CODE_W-1:0] mem_r   [NCODES];
  logic [CODE_W-1:0] mem_nxt [NCODES];

  genvar g;
  generate
    for (g = 0; g < NCODES; g++) begin : g_ent
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (wr_en && wr_idx == IDX_W'(g)) begin
          mem_nxt[g] = wr_code;
        end
      end
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_r[g] <= '0;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  assign host_code = mem_r[host_idx];
  assign seq_code  = mem_r[seq_idx];
endmodule

// File: tpts_sequencer.sv
// tpts_sequencer: pulse template sequencer with its register port
// assumes an 8-bit register port synchronous to ref_clk, ref_clk as
// the high-speed clock, line clock and pulse inputs from another domain
`timescale 1ns/100ps
module tpts_sequencer
  import tpts_pkg::*;
#(
  parameter int unsigned CODE_W = TPTS_CODE_W
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // line side inputs
  input  wire logic              transmit_line_clock,
  input  wire logic              pulse_pos,
  input  wire logic              pulse_neg,
  // converter codes
  output logic      [CODE_W-1:0] line_out_positive,
  output logic      [CODE_W-1:0] line_out_negative,
  // monitor slicer results and recovery inputs
  input  wire logic              mon_pos,
  input  wire logic              mon_neg,
  input  wire logic              line_rx_pos,
  input  wire logic              line_rx_neg,
  output logic                   receive_clock_recovery_pos,
  output logic                   receive_clock_recovery_neg,
  // mode levels to the rest of the device
  output logic                   receive_unipolar_select,
  output logic                   transmit_unipolar_select,
  output logic                   metallic_loopback
);
  initial begin
    if (CODE_W != TPTS_CODE_W) $error("code width fixed by the templates");
  end

  // registers
  logic [7:0] rx_cfg_r, rx_cfg_nxt, tx_cfg_r, tx_cfg_nxt;
  logic [7:0] diag_r, diag_nxt, llen_r, llen_nxt;
  logic [TPTS_IDX_W-1:0] cidx_r, cidx_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [CODE_W-1:0] host_code, seq_code;
  logic code_wr;

  assign code_wr = reg_wr && reg_addr == TPTS_CDATA_A;

  always_comb begin
    rx_cfg_nxt = rx_cfg_r;
    tx_cfg_nxt = tx_cfg_r;
    diag_nxt   = diag_r;
    llen_nxt   = llen_r;
    cidx_nxt   = cidx_r;
    if (reg_wr) begin
      unique case (reg_addr)
        TPTS_RX_CFG_A: rx_cfg_nxt = reg_wdata;
        TPTS_TX_CFG_A: tx_cfg_nxt = reg_wdata;
        TPTS_DIAG_A:   diag_nxt   = reg_wdata;
        TPTS_LLEN_A:   llen_nxt   = reg_wdata;
        TPTS_CIDX_A:   cidx_nxt   = reg_wdata[TPTS_IDX_W-1:0];
        default:       ;
      endcase
    end
    rdata_nxt = TPTS_REG_RST;
    if (reg_rd) begin
      unique case (reg_addr)
        TPTS_RX_CFG_A: rdata_nxt = rx_cfg_r;
        TPTS_TX_CFG_A: rdata_nxt = tx_cfg_r;
        TPTS_DIAG_A:   rdata_nxt = diag_r;
        TPTS_LLEN_A:   rdata_nxt = llen_r;
        TPTS_CIDX_A:   rdata_nxt = {5'h00, cidx_r};
        TPTS_CDATA_A:  rdata_nxt = {4'h0, host_code};
        default:       rdata_nxt = TPTS_REG_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cfg_r  <= TPTS_REG_RST;
      tx_cfg_r  <= TPTS_REG_RST;
      diag_r    <= TPTS_REG_RST;
      llen_r    <= TPTS_LLEN_RST;
      cidx_r    <= TPTS_IDX_ZERO;
      rdata_r   <= TPTS_REG_RST;
    end else begin
      rx_cfg_r  <= rx_cfg_nxt;
      tx_cfg_r  <= tx_cfg_nxt;
      diag_r    <= diag_nxt;
      llen_r    <= llen_nxt;
      cidx_r    <= cidx_nxt;
      rdata_r   <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // custom codes
  logic [TPTS_IDX_W-1:0] step_r, step_nxt;
  tpts_code_store #(
    .CODE_W (CODE_W),
    .NCODES (TPTS_NCODES),
    .IDX_W  (TPTS_IDX_W)
  ) u_store (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .wr_en     (code_wr),
    .wr_idx    (cidx_r),
    .wr_code   (reg_wdata[CODE_W-1:0]),
    .host_idx  (cidx_r),
    .host_code (host_code),
    .seq_idx   (step_r),
    .seq_code  (seq_code)
  );

  // line inputs cross in through two flip-flops
  logic [2:0] sy1_r, sy2_r;
  logic lclk_d_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_r    <= 3'h0;
      sy2_r    <= 3'h0;
      lclk_d_r <= 1'b0;
    end else begin
      sy1_r    <= {transmit_line_clock, pulse_pos, pulse_neg};
      sy2_r    <= sy1_r;
      lclk_d_r <= sy2_r[2];
    end
  end

  // the sequence is stepped on ref_clk rising edges; this clock stands for
  // the high-speed clock, a fixed half-period earlier than its falling edge
  tpts_state_t st_r, st_nxt;
  logic        neg_r, neg_nxt;
  logic [CODE_W-1:0] pos_o_r, pos_o_nxt, neg_o_r, neg_o_nxt;
  logic        start, shaper_on, sel_preset;
  logic [CODE_W-1:0] code_now;
  logic [2:0]  llf;

  assign llf        = llen_r[TPTS_LLF_LO +: 3];
  assign shaper_on  = !tx_cfg_r[TPTS_TX_UNI_B];
  assign start      = lclk_d_r && !sy2_r[2] && (sy2_r[1] ^ sy2_r[0]);
  // custom codes only once re-enabled; otherwise the preset table
  assign sel_preset = !llen_r[TPTS_CUST_EN_B];
  // select bit clear also falls back to the shortest template
  assign code_now   = sel_preset ?
                      TPTS_PRESET[llen_r[TPTS_TSEL_B] ? llf : 3'h0][step_r]
                      : seq_code;

  always_comb begin
    st_nxt    = st_r;
    step_nxt  = step_r;
    neg_nxt   = neg_r;
    pos_o_nxt = TPTS_CODE_ZERO;
    neg_o_nxt = TPTS_CODE_ZERO;
    unique case (st_r)
      TPTS_IDLE: begin
        if (start && shaper_on) begin
          st_nxt   = TPTS_BODY;
          step_nxt = TPTS_IDX_ZERO;
          neg_nxt  = sy2_r[0];
        end
      end
      TPTS_BODY, TPTS_TAIL: begin
        // body on the polarity side, tail on the other
        if ((st_r == TPTS_BODY) != neg_r) pos_o_nxt = code_now;
        else neg_o_nxt = code_now;
        step_nxt = step_r + 3'h1;
        if (step_r == 3'(TPTS_BODY_N - 1)) st_nxt = TPTS_TAIL;
        if (step_r == TPTS_IDX_LAST) begin
          st_nxt   = TPTS_IDLE;
          step_nxt = TPTS_IDX_ZERO;
        end
        if (!shaper_on) begin
          st_nxt   = TPTS_IDLE;
          step_nxt = TPTS_IDX_ZERO;
        end
      end
      default: begin
        st_nxt   = TPTS_IDLE;
        step_nxt = TPTS_IDX_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= TPTS_IDLE;
      step_r  <= TPTS_IDX_ZERO;
      neg_r   <= 1'b0;
      pos_o_r <= TPTS_CODE_ZERO;
      neg_o_r <= TPTS_CODE_ZERO;
    end else begin
      st_r    <= st_nxt;
      step_r  <= step_nxt;
      neg_r   <= neg_nxt;
      pos_o_r <= pos_o_nxt;
      neg_o_r <= neg_o_nxt;
    end
  end
  assign line_out_positive = pos_o_r;
  assign line_out_negative = neg_o_r;

  // loopback mux; monitor levels come from fixed-threshold slicers, so long
  // templates may loop back wrong data; loopback does not force the shortest template
  logic [1:0] msy1_r, msy2_r, rsy1_r, rsy2_r, rec_r, rec_nxt;
  logic [2:0] mode_r, mode_nxt;
  always_comb begin
    mode_nxt = {rx_cfg_r[TPTS_RX_UNI_B], tx_cfg_r[TPTS_TX_UNI_B],
                diag_r[TPTS_MLB_B]};
    rec_nxt  = diag_r[TPTS_MLB_B] ? msy2_r : rsy2_r;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msy1_r <= 2'h0;
      msy2_r <= 2'h0;
      rsy1_r <= 2'h0;
      rsy2_r <= 2'h0;
      rec_r  <= 2'h0;
      mode_r <= 3'h0;
    end else begin
      msy1_r <= {mon_pos, mon_neg};
      msy2_r <= msy1_r;
      rsy1_r <= {line_rx_pos, line_rx_neg};
      rsy2_r <= rsy1_r;
      rec_r  <= rec_nxt;
      mode_r <= mode_nxt;
    end
  end
  assign receive_clock_recovery_pos = rec_r[1];
  assign receive_clock_recovery_neg = rec_r[0];
  assign receive_unipolar_select    = mode_r[2];
  assign transmit_unipolar_select   = mode_r[1];
  assign metallic_loopback          = mode_r[0];
endmodule

// File: tpts_line_model.sv
// tpts_line_model: driver outputs seen by fixed-threshold slicers
// assumes the converter codes stand for the line levels
`timescale 1ns/100ps
module tpts_line_model
  import tpts_pkg::*;
#(
  parameter logic [3:0] SLICE_LVL = 4'h6
) (
  // converter codes
  input wire logic [3:0] line_out_positive,
  input wire logic [3:0] line_out_negative,
  // slicer results
  output logic           mon_pos,
  output logic           mon_neg
);
  // one fixed level, so a tall long-line tail slices as a mark
  assign mon_pos = line_out_positive > SLICE_LVL;
  assign mon_neg = line_out_negative > SLICE_LVL;
endmodule

// File: tpts_sequencer_chk.sv
// tpts_sequencer_chk: port assertions bound to the sequencer
// assumes the single ref_clk domain
`timescale 1ns/100ps
module tpts_sequencer_chk
  import tpts_pkg::*;
(
  // clock
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // line side
  input wire logic [3:0] line_out_positive,
  input wire logic [3:0] line_out_negative,
  input wire logic       mon_pos,
  input wire logic       receive_clock_recovery_pos,
  input wire logic       transmit_unipolar_select,
  input wire logic       metallic_loopback
);
  logic p_on, n_on, idle;
  assign p_on = |line_out_positive;
  assign n_on = |line_out_negative;
  assign idle = !p_on && !n_on;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence pos_only; (p_on && !n_on)[*4]; endsequence
  sequence neg_only; (n_on && !p_on)[*4]; endsequence
  a_pos_pulse:
    assert property ($past(idle) && p_on |-> pos_only ##1 neg_only ##1 idle)
      else $error("positive pulse shape");
  a_neg_pulse:
    assert property ($past(idle) && n_on |-> neg_only ##1 pos_only ##1 idle)
      else $error("negative pulse shape");
  a_idle_ground:
    assert property (!(p_on && n_on)) else $error("both sides driven");
  a_uni_quiet:
    assert property (transmit_unipolar_select[*3] |-> idle)
      else $error("pulse in unipolar mode");
  // mode levels pass the register and then the output flop: two edges
  a_tx_uni_lvl:
    assert property (reg_wr && reg_addr == TPTS_TX_CFG_A |-> ##2
      transmit_unipolar_select == $past(reg_wdata[0], 2)) else $error("uni");
  a_mlb_lvl:
    assert property (reg_wr && reg_addr == TPTS_DIAG_A |-> ##2
      metallic_loopback == $past(reg_wdata[3], 2)) else $error("loop level");
  a_idx_width:
    assert property (reg_rd && reg_addr == TPTS_CIDX_A |=>
      reg_rdata[7:3] == 5'h00) else $error("index too wide");
  a_loop_route:
    assert property (metallic_loopback[*4] |->
      receive_clock_recovery_pos == $past(mon_pos, 3)) else $error("route");
endmodule
bind tpts_sequencer tpts_sequencer_chk i_chk (
  .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .line_out_positive, .line_out_negative, .mon_pos,
  .receive_clock_recovery_pos, .transmit_unipolar_select, .metallic_loopback);

// File: test_transmit_pulse_template_sequencer.sv
// test_transmit_pulse_template_sequencer: self-checking bench
// assumes the line model on the codes and the bound checker
`timescale 1ns/100ps
module test_transmit_pulse_template_sequencer
  import tpts_pkg::*;
;
  logic       ref_clk, rst_b, reg_wr, reg_rd, pulse_pos, pulse_neg;
  logic       transmit_line_clock, mon_pos, mon_neg, line_rx_pos, line_rx_neg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] line_out_positive, line_out_negative;
  logic       receive_clock_recovery_pos, receive_clock_recovery_neg;
  logic       receive_unipolar_select, transmit_unipolar_select;
  logic       metallic_loopback;
  int         bad_count, checks, cyc;
  int         mreg [256] = '{default: 0};
  int         cust [8] = '{default: 0};
  int         sh [8] = '{11, 10, 10, 10, 3, 3, 2, 1};
  logic [7:0] regs [7] = '{8'h03, 8'h04, 8'h0a, 8'h14, 8'h16, 8'h17, 8'h55};
  tpts_sequencer i_tpts_sequencer (
    .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .transmit_line_clock, .pulse_pos, .pulse_neg, .line_out_positive,
    .line_out_negative, .mon_pos, .mon_neg, .line_rx_pos, .line_rx_neg,
    .receive_clock_recovery_pos, .receive_clock_recovery_neg,
    .receive_unipolar_select, .transmit_unipolar_select, .metallic_loopback);
  tpts_line_model i_tpts_line_model (
    .line_out_positive, .line_out_negative, .mon_pos, .mon_neg);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (++cyc > 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // strobes are reassigned once per call, just after the edge
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic idle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
    mreg[a] = a == 8'h16 ? d & 7 : d;
    if (a == 8'h17) cust[mreg['h16]] = d & 15;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    chk(reg_rdata, 8'(a == 8'h17 ? cust[mreg['h16]] : mreg[a]));
  endtask
  task automatic pulse(input logic pol, live);
    int n, l, c;
    idle();
    {pulse_pos, pulse_neg, transmit_line_clock} = {pol, !pol, 1'b0};
    for (n = 0; n < 12 && {line_out_positive, line_out_negative} == 0; n++)
      idle();
    l = mreg['h14];
    for (int i = 0; i < 8 && live; i++) begin
      c = l[7] ? cust[i] : (!l[6] || l[2:0] == 0) ? sh[i] :
        TPTS_PRESET[l[2:0]][i];
      chk({line_out_positive, line_out_negative},
        8'(pol == (i < 4) ? c << 4 : c));
      idle();
    end
    chk({line_out_positive, line_out_negative}, 8'h00);
    {pulse_pos, pulse_neg, transmit_line_clock} = 3'b001;
    repeat (6) idle();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, pulse_pos, pulse_neg, line_rx_pos} = '0;
    {reg_addr, reg_wdata, line_rx_neg} = '0;
    transmit_line_clock = 1'b1;
    mreg['h14] = 'h40;
    void'($urandom(71));
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (regs[k]) rd(regs[k]);
    $display("reset test done");
    for (int l = 0; l < 9; l++) begin
      wr(8'h14, l < 8 ? 8'(8'h40 + l) : 8'h05);
      pulse(1'($urandom % 2), 1'b1);
    end
    $display("preset test done");
    wr(8'h14, 8'h40);
    for (int i = 0; i < 8; i++) begin
      wr(8'h16, 8'(i));
      wr(8'h17, 8'(1 + $urandom % 15));
    end
    for (int i = 7; i >= 0; i--) begin
      wr(8'h16, 8'(i + 8));
      rd(8'h16);
      rd(8'h17);
    end
    wr(8'h14, 8'hc0);
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    $display("custom test done");
    wr(8'h04, 8'h01);
    idle();
    chk(8'(transmit_unipolar_select), 8'h01);
    pulse(1'b1, 1'b0);
    wr(8'h04, 8'h00);
    pulse(1'b0, 1'b1);
    $display("unipolar test done");
    line_rx_pos = 1'b1;
    line_rx_neg = 1'b1;
    repeat (4) idle();
    chk(8'({receive_clock_recovery_pos, receive_clock_recovery_neg}),
      8'h03);
    wr(8'h03, 8'h01);
    idle();
    chk(8'(receive_unipolar_select), 8'h01);
    wr(8'h0a, 8'h08);
    wr(8'h03, 8'h00);
    wr(8'h14, 8'h40);
    repeat (4) idle();
    chk(8'({receive_clock_recovery_pos, receive_clock_recovery_neg,
      metallic_loopback, receive_unipolar_select}), 8'h02);
    pulse(1'b1, 1'b1);
    $display("loopback test done");
    give_verdict();
  end
endmodule
